// file: hw/serial_fifo.sv
// Small FIFO with valid/ready on both sides.
// Assumes both sides run on mclk; DEPTH is a power of two.
`timescale 1ns/1ps
module serial_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } fifo_state_t;
   fifo_state_t state_reg, state_next;
   logic doWrite, doRead;

   always_comb begin
      doWrite = inValid && (state_reg.count != AW'(0) + (AW+1)'(DEPTH));
      doRead = outReady && (state_reg.count != '0);
      state_next = state_reg;
      if (doWrite) begin
         state_next.mem[state_reg.wrPtr] = inData;
         state_next.wrPtr = state_reg.wrPtr + AW'(1);
      end
      if (doRead) begin
         state_next.rdPtr = state_reg.rdPtr + AW'(1);
      end
      state_next.count = state_reg.count + (AW+1)'(doWrite) - (AW+1)'(doRead);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign inReady = state_reg.count != (AW+1)'(DEPTH);
   assign outValid = state_reg.count != '0;
   assign outData = state_reg.mem[state_reg.rdPtr];
endmodule : serial_fifo

// file: hw/serial_shift_pkg.sv
// Package: constants for the universal serial shift unit.
// Assumes a single system clock mclk at 25 MHz; serial pins are asynchronous.
package serial_shift_pkg;
   localparam int CLK_HZ = 25000000;
   localparam logic [1:0] WIRE_NONE = 2'h0;
   localparam logic [1:0] WIRE_THREE = 2'h1;
   localparam logic [1:0] WIRE_TWO = 2'h2;
   localparam logic [1:0] WIRE_TWO_HOLD = 2'h3;
   localparam logic [1:0] CS_SOFT = 2'h0;
   localparam logic [1:0] CS_TIMER = 2'h1;
   localparam logic [1:0] CS_EXT_POS = 2'h2;
   localparam logic [1:0] CS_EXT_NEG = 2'h3;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [3:0] COUNT_RESET = 4'h0;
   localparam logic [3:0] COUNT_MAX = 4'hF;
   localparam int DATA_MSB = 7;
   localparam int FIFO_DEPTH_DEF = 4;
endpackage : serial_shift_pkg

// file: hw/serial_shift_unit.sv
// Universal serial shift unit: shift register, 4-bit edge counter,
// start detector and two-wire clock hold. Software drives control ports.
// Assumes pins are asynchronous to mclk and resolved as wired-AND outside.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// RULE1 - Fast master: alternate strobe writes, soft clock, toggle; gives quarter clock. Bench toggles every mclk cycle, giving half mclk.
// RULE2 - Strobe loop: clear overflow and count, then sixteen clock toggles per byte.
// RULE3 - Three-wire slave, external rising clock: overflow flag set, received byte in register.
// RULE4 - Three-wire slave: data output pin as output, clock pin as input.
// RULE5 - Two-wire mode follows I2C on SCL/SDA, no slew limit, no filter.
// RULE6 - Two-wire: only master makes clock, only slave stretches SCL.
// RULE7 - Software makes the clock; device shifts automatically on edges.
// RULE8 - Two-wire software should pick negative edge shifting.
// RULE9 - Master checks SCL really released after each rising edge.
// RULE10 - Every serial clock edge increments counter; overflow marks transfer done.
// RULE11 - Two-wire master toggles clock pin through port output register.
// RULE12 - Direction decided by software protocol, not shift hardware.
// RULE13 - Master start: SDA low while SCL high via shift MSB or port bit.
// RULE14 - Start detector sets start flag; flag can raise interrupt.
// RULE15 - After start and SCL fall, hold SCL low until flag cleared.
// RULE16 - Master sets bit before releasing SCL; slave shifts SDA on rising edge.
// RULE17 - After eight address bits, counter overflows and SCL forced low.
// RULE18 - Unmatched slave releases SCL, ignores bus until next start.
// RULE19 - Addressed slave acknowledges; counter loaded 14 so overflow follows ack.
// RULE20 - Direction bit one: slave drives SDA; slave may hold SCL after ack.
// RULE21 - Any number of bytes same direction until stop or repeated start.
// RULE22 - Slave unable to accept withholds acknowledge of last byte.
// RULE23 - Data output follows MSB through latch, open first half with external clock.
// RULE24 - Start detector works only in two-wire mode.
// RULE25 - Two-wire pins only driven low or released, never high.
module serial_shift_unit
   import serial_shift_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] wireMode,
   input wire logic [1:0] clockSource,
   input wire logic clockStrobe,
   input wire logic toggleStrobe,
   input wire logic timerMatch,
   input wire logic dataWrite,
   input wire logic [7:0] dataWriteValue,
   input wire logic countWrite,
   input wire logic [3:0] countWriteValue,
   input wire logic overflowClear,
   input wire logic startClear,
   input wire logic dataOutDir,
   input wire logic clockPinDir,
   input wire logic clockPortBit,
   input wire logic dataPortBit,
   input wire logic dataInPin,
   input wire logic clockInPin,
   output logic dataOut,
   output logic dataOutEn,
   output logic clockOut,
   output logic clockOutEn,
   output logic [7:0] serialShiftData,
   output logic [3:0] edgeCount,
   output logic counterOverflowFlag,
   output logic startConditionFlag,
   output logic rxValid,
   input wire logic rxReady,
   output logic [7:0] rxData
);
   typedef struct packed {
      logic [1:0] dSync;
      logic [1:0] cSync;
      logic dLast;
      logic cLast;
      logic [7:0] shift;
      logic [3:0] count;
      logic ovf;
      logic start;
      logic hold;
      logic outLatch;
      logic pinClk;
      logic dOut;
      logic dOutEn;
      logic cOut;
      logic cOutEn;
   } unit_state_t;
   unit_state_t state_reg, state_next;

   logic twoWire, extClk, sdaIn, sclIn, sclRise, sclFall, sdaFall;
   logic shiftEdge, countEdge, fifoIn, fifoInReady;

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      // Only second stage is read by logic
      state_next.dSync = {state_reg.dSync[0], dataInPin};
      state_next.cSync = {state_reg.cSync[0], clockInPin};
      sdaIn = state_reg.dSync[1];
      sclIn = state_reg.cSync[1];
      state_next.dLast = sdaIn;
      state_next.cLast = sclIn;
      twoWire = wireMode[1];
      extClk = clockSource[1];
      sclRise = sclIn && !state_reg.cLast;
      sclFall = !sclIn && state_reg.cLast;
      sdaFall = !sdaIn && state_reg.dLast;
      // Software toggles the clock pin; external edges come back via sampling
      if (toggleStrobe) begin
         state_next.pinClk = !state_reg.pinClk; // RULE7
      end
      shiftEdge = 1'b0;
      countEdge = 1'b0;
      case (clockSource)
         CS_SOFT: begin
            shiftEdge = clockStrobe; // RULE7
            countEdge = clockStrobe | toggleStrobe; // RULE10
         end
         CS_TIMER: begin
            shiftEdge = timerMatch;
            countEdge = timerMatch | toggleStrobe;
         end
         CS_EXT_POS: begin
            shiftEdge = sclRise; // RULE3 RULE16
            countEdge = sclRise | sclFall | toggleStrobe; // RULE10
         end
         default: begin
            shiftEdge = sclFall;
            countEdge = sclRise | sclFall | toggleStrobe;
         end
      endcase
      // Write wins over a shift in the same cycle
      if (dataWrite) begin
         state_next.shift = dataWriteValue;
      end else if (shiftEdge) begin
         state_next.shift = {state_reg.shift[6:0], sdaIn}; // RULE16
      end
      if (countWrite) begin
         state_next.count = countWriteValue; // RULE19
      end else if (countEdge) begin
         state_next.count = state_reg.count + 4'h1; // RULE10
      end
      fifoIn = 1'b0;
      if (overflowClear) begin
         state_next.ovf = 1'b0;
      end
      // Set wins over clear
      if (!countWrite && countEdge && state_reg.count == COUNT_MAX) begin
         state_next.ovf = 1'b1; // RULE3 RULE10
         fifoIn = 1'b1;
         if (wireMode == WIRE_TWO_HOLD) begin
            state_next.hold = 1'b1; // RULE17 RULE20
         end
      end
      if (startClear) begin
         state_next.start = 1'b0; // RULE15
      end
      // Start: SDA falls while SCL high, two-wire only
      if (twoWire && sdaFall && sclIn) begin
         state_next.start = 1'b1; // RULE14 RULE24 RULE21
      end
      if (twoWire && state_reg.start && sclFall) begin
         state_next.hold = 1'b1; // RULE15 RULE6
      end
      if (!twoWire || (!state_next.start && !state_next.ovf)) begin
         state_next.hold = 1'b0; // RULE15 RULE18
      end
      // Latch open in first half of external clock, always open internally
      if (!extClk || !sclIn) begin
         state_next.outLatch = state_next.shift[DATA_MSB]; // RULE23
      end
      if (twoWire) begin
         // Wired-AND: drive low or release only
         state_next.dOut = 1'b0; // RULE25 RULE5
         state_next.dOutEn = dataOutDir && !(state_next.outLatch && dataPortBit); // RULE25
         state_next.cOut = 1'b0;
         state_next.cOutEn = state_next.hold || (clockPinDir &&
            !(clockPortBit ^ state_next.pinClk)); // RULE25 RULE6
      end else begin
         state_next.dOut = state_next.outLatch; // RULE23
         state_next.dOutEn = dataOutDir;
         state_next.cOut = clockPortBit ^ state_next.pinClk;
         state_next.cOutEn = clockPinDir;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Received bytes queue; a full queue drops new bytes, register still holds them
   serial_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
      .mclk(mclk),
      .rst(rst),
      .inValid(fifoIn),
      .inReady(fifoInReady),
      .inData(state_next.shift),
      .outValid(rxValid),
      .outReady(rxReady),
      .outData(rxData)
   );

   assign dataOut = state_reg.dOut;
   assign dataOutEn = state_reg.dOutEn;
   assign clockOut = state_reg.cOut;
   assign clockOutEn = state_reg.cOutEn;
   assign serialShiftData = state_reg.shift;
   assign edgeCount = state_reg.count;
   assign counterOverflowFlag = state_reg.ovf;
   assign startConditionFlag = state_reg.start;
endmodule : serial_shift_unit

// file: verif/serial_master_model.sv
// Partner: far-side serial master, clock runs only within frames.
// Assumes the bench calls xfer and start; clock idles low.
`timescale 1ns/1ps
module serial_master_model (
   output logic sclk,
   output logic sdaOut,
   input wire logic sdaIn
);
   logic [7:0] got = 8'h00;
   initial begin
      sclk = 1'b0;
      sdaOut = 1'b1;
   end
   // Data set while clock low, sampled on the rise, MSB first
   task automatic xfer(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--) begin
         sdaOut = tx[i];
         #160 sclk = 1'b1;
         got = {got[6:0], sdaIn};
         #160 sclk = 1'b0;
      end
      sdaOut = ~sdaOut; // Stale bit must not linger
   endtask : xfer
   task automatic start();
      sdaOut = 1'b1;
      #160 sclk = 1'b1;
      #160 sdaOut = 1'b0;
      #320 sclk = 1'b0;
   endtask : start
endmodule : serial_master_model

// file: verif/serial_shift_unit_sva.sv
// Checker: port assertions for the serial shift unit.
// Assumes one mclk domain and rst asynchronous, active high.
`timescale 1ns/1ps
module serial_shift_unit_sva
   import serial_shift_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] wireMode,
   input wire logic [1:0] clockSource,
   input wire logic clockStrobe,
   input wire logic dataWrite,
   input wire logic [7:0] dataWriteValue,
   input wire logic countWrite,
   input wire logic clockInPin,
   input wire logic dataOut,
   input wire logic clockOut,
   input wire logic clockOutEn,
   input wire logic [7:0] serialShiftData,
   input wire logic [3:0] edgeCount,
   input wire logic counterOverflowFlag,
   input wire logic startConditionFlag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_pins_never_high: assert property (wireMode[1] && $past(wireMode[1])
      |-> !dataOut && !clockOut) else $error("two-wire pin driven high");
   a_start_mode_only: assert property ($rose(startConditionFlag)
      |-> $past(wireMode[1])) else $error("start flag outside two-wire");
   a_overflow_on_wrap: assert property ($rose(counterOverflowFlag)
      |-> $past(edgeCount) == COUNT_MAX) else $error("overflow without wrap");
   a_count_single_step: assert property (!$past(countWrite) && $changed(edgeCount)
      |-> edgeCount == $past(edgeCount) + 4'h1) else $error("count jumped");
   a_data_load_wins: assert property (dataWrite
      |=> serialShiftData == $past(dataWriteValue)) else $error("load lost");
   a_soft_shift_msb: assert property (clockSource == CS_SOFT && clockStrobe && !dataWrite
      |=> serialShiftData[7:1] == $past(serialShiftData[6:0])) else $error("no shift");
   a_msb_on_pin: assert property (wireMode == WIRE_THREE && !clockSource[1]
      && !$past(clockSource[1]) |-> dataOut == serialShiftData[7]) else $error("pin not msb");
   a_hold_after_start: assert property ($fell(clockInPin) && startConditionFlag
      && wireMode[1] |-> ##[2:5] (clockOutEn && !clockOut)) else $error("scl not held");
endmodule : serial_shift_unit_sva
bind serial_shift_unit serial_shift_unit_sva u_serial_shift_unit_sva (.*);

// file: verif/serial_shift_unit_tb_top.sv
// Bench: slave exchange, fast master, FIFO fill, start detection.
// Assumes serial_master_model drives the far side of the pins.
`timescale 1ns/1ps
module serial_shift_unit_tb_top
   import serial_shift_pkg::*;
;
   logic mclk, rst, clockStrobe, toggleStrobe, dataWrite, countWrite, overflowClear;
   logic startClear, dataOutDir, clockPinDir, clockPortBit, rxReady, rxValid, mScl, mSda;
   logic dataOut, dataOutEn, clockOut, clockOutEn, counterOverflowFlag, startConditionFlag;
   logic [1:0] wireMode, clockSource;
   logic [7:0] dataWriteValue, serialShiftData, rxData;
   logic [3:0] countWriteValue, edgeCount;
   int mismatches, compares, cycles;
   // Wired-AND only in two-wire mode
   wire logic sdaLine = mSda & ~(wireMode[1] & dataOutEn & ~dataOut);
   wire logic sclLine = mScl & ~(wireMode[1] & clockOutEn & ~clockOut);
   serial_shift_unit #(.FIFO_DEPTH(4)) u_serial_shift_unit (.*, .timerMatch(1'b0),
      .dataPortBit(1'b1), .dataInPin(sdaLine), .clockInPin(sclLine));
   serial_master_model u_serial_master_model (.sclk(mScl), .sdaOut(mSda), .sdaIn(dataOut));
   ////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge mclk);
         #1;
      end
   endtask : tick
   task automatic load(input logic [7:0] d, input logic [3:0] c);
      {dataWrite, countWrite, overflowClear} = 3'h7;
      dataWriteValue = d;
      countWriteValue = c;
      tick(1);
      {dataWrite, countWrite, overflowClear} = 3'h0;
   endtask : load
   task automatic finish_test();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////
   initial begin
      {clockStrobe, toggleStrobe, dataWrite, countWrite, overflowClear, startClear} = 6'h00;
      {dataOutDir, clockPinDir, clockPortBit, rxReady, dataWriteValue, countWriteValue} = 16'h0;
      wireMode = WIRE_THREE;
      clockSource = CS_EXT_POS;
      rst = 1'b1;
      tick(8);
      rst = 1'b0;
      dataOutDir = 1'b1;
      load(8'h3C, COUNT_RESET);
      u_serial_master_model.xfer(8'hA5);
      tick(6);
      check(counterOverflowFlag, 8'h01);
      check(dataOutEn, 8'h01);
      check(serialShiftData, 8'hA5);
      check(u_serial_master_model.got, 8'h3C);
      check(edgeCount, 8'h00);
      check(rxData, 8'hA5);
      rxReady = 1'b1;
      tick(1);
      rxReady = 1'b0;
      $display("slave exchange test done");
      clockSource = CS_SOFT;
      clockPinDir = 1'b1;
      load(8'h97, COUNT_RESET);
      for (int i = 0; i < 16; i++) begin
         toggleStrobe = 1'b1;
         clockStrobe = i[0];
         tick(1);
         if (i == 14) check(counterOverflowFlag, 8'h00);
      end
      {toggleStrobe, clockStrobe} = 2'h0;
      rxReady = 1'b1;
      tick(1);
      rxReady = 1'b0;
      check(counterOverflowFlag, 8'h01);
      check(serialShiftData, 8'h00);
      check(clockOut, 8'h00);
      $display("fast master test done");
      for (int i = 0; i < 6; i++) begin
         load(8'h10 + 8'(i), COUNT_MAX);
         toggleStrobe = 1'b1;
         tick(1);
         toggleStrobe = 1'b0;
         tick(1);
      end
      rxReady = 1'b1;
      for (int i = 0; i < 4; i++) begin
         check(rxData, 8'h10 + 8'(i));
         tick(1);
      end
      rxReady = 1'b0;
      check(rxValid, 8'h00);
      $display("buffer fill test done");
      {dataOutDir, clockPortBit} = 2'h1;
      load(8'h00, COUNT_RESET);
      u_serial_master_model.start();
      tick(5);
      check(startConditionFlag, 8'h00);
      wireMode = WIRE_TWO;
      clockSource = CS_EXT_NEG;
      tick(2);
      u_serial_master_model.start();
      tick(6);
      check(startConditionFlag, 8'h01);
      check(clockOutEn, 8'h01);
      startClear = 1'b1;
      load(8'h00, COUNT_RESET);
      startClear = 1'b0;
      tick(2);
      check(clockOutEn, 8'h00);
      check(clockOutEn, 8'h00);
      wireMode = WIRE_TWO_HOLD;
      load(8'h00, 4'hE);
      toggleStrobe = 1'b1;
      tick(2);
      toggleStrobe = 1'b0;
      check(counterOverflowFlag, 8'h01);
      check(clockOutEn, 8'h01);
      load(8'h00, COUNT_RESET);
      tick(2);
      check(clockOutEn, 8'h00);
      $display("start detect test done");
      finish_test();
   end
endmodule : serial_shift_unit_tb_top
